// ### tb/dasmc_chk.sv
// Port assertions for the converter status and mode control block.
`timescale 1ns/1ps
module dasmc_chk (
    // Clock, reset and register port.
    input wire       ref_clk, rst_b, sfr_wr, sfr_rd,
    input wire [7:0] sfr_addr, sfr_rdata,
    // Converter side.
    input wire       pri_saturated, pri_ext_ref, aux_ext_ref, pri_run, aux_run,
    input wire       pri_result_we, aux_result_we, pri_clamp_ones, aux_clamp_ones, converter_restart,
    input wire [2:0] mode_select
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire rd_st = sfr_rd && sfr_addr == 8'hd8;
    wire rd_md = sfr_rd && sfr_addr == 8'hd1;
    wire wr_md = sfr_wr && sfr_addr == 8'hd1;
    sequence s_single_fin; pri_result_we && !wr_md && mode_select == 3'h2; endsequence
    sequence s_fin_read; pri_result_we ##1 !sfr_wr ##1 rd_st; endsequence
    sequence s_sat_read; pri_result_we && pri_saturated ##1 !sfr_wr ##1 rd_st; endsequence
    chk_restart_on_write: assert property (wr_md |-> converter_restart) else $error("no restart on mode write");
    chk_run_needs_mode: assert property (pri_run || aux_run |-> mode_select != 3'h0) else $error("run at md 0");
    chk_single_return: assert property (s_single_fin |=> mode_select == 3'h0 && !pri_run) else $error("no return");
    chk_pri_blocked: assert property (pri_result_we |=> !pri_result_we) else $error("pri not blocked");
    chk_aux_blocked: assert property (aux_result_we |=> !aux_result_we) else $error("aux not blocked");
    chk_ready_read: assert property (s_fin_read |=> sfr_rdata[7]) else $error("ready not set");
    chk_error_read: assert property (s_sat_read |=> sfr_rdata[3]) else $error("error not set");
    chk_status_resv: assert property (rd_st |=> sfr_rdata[1:0] == 2'h0) else $error("status reserved");
    chk_mode_resv: assert property (rd_md |=> (sfr_rdata & 8'hc8) == 8'h00) else $error("mode reserved");
    chk_mode_read: assert property (rd_md |=> sfr_rdata[2:0] == $past(mode_select)) else $error("mode read");
    chk_clamp_ext: assert property (pri_clamp_ones |-> pri_ext_ref) else $error("clamp without ext");
    chk_ref_idle: assert property (!pri_run && !aux_run |=> !pri_clamp_ones && !aux_clamp_ones) else $error("idle clamp");
endmodule
bind dasmc_ctrl dasmc_chk chk (.ref_clk, .rst_b, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_rdata, .pri_saturated, .pri_ext_ref,
    .aux_ext_ref, .pri_run, .aux_run, .pri_result_we, .aux_result_we, .pri_clamp_ones, .aux_clamp_ones,
    .converter_restart, .mode_select);

// ### tb/tb_top.sv
// Self-checking bench for the converter status and mode control block.
`timescale 1ns/1ps
module tb_top;
    reg        ref_clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0;
    reg  [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rv;
    reg        pri_done = 0, pri_saturated = 0, pri_cal_fault = 0, pri_ext_ref = 0, reference_missing = 0;
    reg        aux_done = 0, aux_saturated = 0, aux_cal_fault = 0, aux_ext_ref = 0, aux_temp_selected = 0;
    wire [7:0] sfr_rdata;
    wire [2:0] mode_select;
    wire       pri_run, aux_run, converter_restart, aux_restart, pri_result_we, aux_result_we;
    wire       pri_coef_we, aux_coef_we, pri_clamp_ones, aux_clamp_ones;
    integer    fail_count = 0, checks_done = 0, cycles = 0, i;
    reg [15:0] rows [0:5] = '{16'hff37, 16'hc901, 16'h2222, 16'h1313, 16'h3434, 16'h0800};
    dasmc_ctrl dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .pri_done(pri_done), .pri_saturated(pri_saturated), .pri_cal_fault(pri_cal_fault),
        .pri_ext_ref(pri_ext_ref), .aux_done(aux_done), .aux_saturated(aux_saturated),
        .aux_cal_fault(aux_cal_fault), .aux_ext_ref(aux_ext_ref), .aux_temp_selected(aux_temp_selected),
        .reference_missing(reference_missing), .pri_run(pri_run), .aux_run(aux_run),
        .mode_select(mode_select), .converter_restart(converter_restart), .aux_restart(aux_restart),
        .pri_result_we(pri_result_we), .aux_result_we(aux_result_we), .pri_coef_we(pri_coef_we),
        .aux_coef_we(aux_coef_we), .pri_clamp_ones(pri_clamp_ones), .aux_clamp_ones(aux_clamp_ones)
    );
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            fail_count = fail_count + 1;
            test_done;
        end
    end
    task chk(input [7:0] seen, exp, input string nm);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp)
            begin
                fail_count = fail_count + 1;
                $display("ERROR %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] a, d);
        begin
            @(negedge ref_clk) {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
            @(negedge ref_clk) sfr_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a, e);
        begin
            @(negedge ref_clk) {sfr_rd, sfr_addr} = {1'b1, a};
            @(negedge ref_clk) sfr_rd = 1'b0;
            chk(sfr_rdata, e, a == 8'hd8 ? "status" : "mode");
        end
    endtask
    // Pulses one converter's done and checks the permitted writes.
    task done(input p, s, f, input [3:0] we);
        begin
            @(negedge ref_clk) {pri_done, aux_done, pri_saturated, aux_saturated, pri_cal_fault, aux_cal_fault} = {p, !p, s, s, f, f};
            #1 chk({pri_result_we, aux_result_we, pri_coef_we, aux_coef_we}, we, "write enables");
            @(negedge ref_clk) {pri_done, aux_done} = 2'b00;
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial
    begin
        repeat (4) @(negedge ref_clk);
        rst_b = 1'b1;
        rd(8'hd8, 8'h00);
        rd(8'hd1, 8'h00);
        rd(8'h80, 8'h00);
        $display("reset test ended");
        for (i = 0; i < 6; i = i + 1)
        begin
            wr(8'hd1, rows[i][15:8]);
            rd(8'hd1, rows[i][7:0]);
            chk(mode_select, rows[i][2:0], "mode_select");
            chk(pri_run, rows[i][5] && rows[i][2:0] != 3'h0, "pri_run");
            chk(aux_run, rows[i][4] && rows[i][2:0] != 3'h0, "aux_run");
        end
        $display("mode table test ended");
        wr(8'hd1, 8'h22);
        done(1, 1, 0, 4'b1000);
        rd(8'hd8, 8'h88);
        rd(8'hd1, 8'h20);
        wr(8'hd1, 8'h23);
        rd(8'hd8, 8'h00);
        done(1, 0, 0, 4'b1000);
        done(1, 0, 0, 4'b0000);
        wr(8'hd8, 8'h7f);
        rd(8'hd8, 8'h00);
        done(1, 0, 0, 4'b1000);
        $display("primary ready test ended");
        aux_temp_selected = 1'b1;
        wr(8'hd1, 8'h14);
        rd(8'hd8, 8'h00);
        done(0, 0, 0, 4'b0000);
        rd(8'hd8, 8'h64);
        rd(8'hd1, 8'h10);
        aux_temp_selected = 1'b0;
        wr(8'hd1, 8'h14);
        rd(8'hd8, 8'h00);
        done(0, 0, 0, 4'b0001);
        rd(8'hd8, 8'h60);
        wr(8'hd1, 8'h24);
        done(1, 0, 1, 4'b0000);
        rd(8'hd8, 8'ha8);
        $display("calibration test ended");
        {pri_ext_ref, reference_missing} = 2'b11;
        wr(8'hd1, 8'h23);
        @(negedge ref_clk);
        chk(pri_clamp_ones, 1'b1, "pri_clamp_ones");
        chk(aux_clamp_ones, 1'b0, "aux_clamp_ones");
        rd(8'hd8, 8'h10);
        reference_missing = 1'b0;
        rd(8'hd8, 8'h00);
        reference_missing = 1'b1;
        wr(8'hd1, 8'h00);
        rd(8'hd8, 8'h00);
        $display("reference test ended");
        wr(8'hd1, 8'h23);
        @(negedge ref_clk) rst_b = 1'b0;
        #1 chk(mode_select, 3'h0, "reset mode_select");
        chk(pri_run, 1'b0, "reset pri_run");
        @(negedge ref_clk) rst_b = 1'b1;
        rd(8'hd1, 8'h00);
        rd(8'hd8, 8'h00);
        $display("mid-run reset test ended");
        test_done;
    end
endmodule

// ### verilog/dasmc_ctrl.v
// Status and mode register control for a primary and an auxiliary converter.
`timescale 1ns/1ps
`include "dasmc_defines.vh"

// Overview of operation
// - Primary ready bit 7 sets when primary conversion or calibration finishes.
// - Primary ready clears on software zero write or mode write starting primary.
// - While primary ready is set, primary result and coefficient writes are blocked.
// - Auxiliary ready bit 6 behaves the same for the auxiliary converter.
// - Calibration-complete bit 5 sets whenever a calibration finishes.
// - Calibration-complete clears only by a mode write starting an operation.
// - Missing-reference bit 4 follows reference detect only while a converter runs.
// - Missing reference with external reference selected forces results to all ones.
// - Primary error bit 3 sets when a written primary result saturated.
// - Primary error also reports a calibration fault that blocked coefficient update.
// - Primary error clears on a mode write starting conversion or calibration.
// - Auxiliary error bit 2 behaves the same for the auxiliary converter.
// - Mode bit 5 runs the primary converter in the selected mode, else powers down.
// - Mode bit 4 runs the auxiliary converter in the selected mode, else powers down.
// - Mode select 000 is power-down and the reset value; others pick operations.
// - After single conversion or calibration, flags update and mode returns to 000.
// - Writing a calibration mode clears both ready flags at once.
// - Auxiliary calibration with temperature input sets aux ready and error, no update.
module dasmc_ctrl
(
    // Clock and reset.
    input  wire        ref_clk,
    input  wire        rst_b,
    // Special function register port.
    input  wire [7:0]  sfr_addr,
    input  wire [7:0]  sfr_wdata,
    input  wire        sfr_wr,
    input  wire        sfr_rd,
    output reg  [7:0]  sfr_rdata,
    // Primary converter events.
    input  wire        pri_done,
    input  wire        pri_saturated,
    input  wire        pri_cal_fault,
    input  wire        pri_ext_ref,
    // Auxiliary converter events.
    input  wire        aux_done,
    input  wire        aux_saturated,
    input  wire        aux_cal_fault,
    input  wire        aux_ext_ref,
    input  wire        aux_temp_selected,
    // Reference detection.
    input  wire        reference_missing,
    // Converter control outputs.
    output wire        pri_run,
    output wire        aux_run,
    output wire [2:0]  mode_select,
    output wire        converter_restart,
    output wire        aux_restart,
    output wire        pri_result_we,
    output wire        aux_result_we,
    output wire        pri_coef_we,
    output wire        aux_coef_we,
    output wire        pri_clamp_ones,
    output wire        aux_clamp_ones
);

    reg  [7:0] converter_mode_control;
    reg  [7:0] converter_status_flags;
    reg  [7:0] next_mode;
    reg  [7:0] next_status;

    wire       mode_wr   = sfr_wr && (sfr_addr == `DASMC_ADDR_MODE);
    wire       status_wr = sfr_wr && (sfr_addr == `DASMC_ADDR_STATUS);
    wire [2:0] wr_md     = sfr_wdata[2:0];
    wire       wr_pri_en = sfr_wdata[`DASMC_BIT_PRI_EN];
    wire       wr_aux_en = sfr_wdata[`DASMC_BIT_AUX_EN];
    wire       wr_start  = mode_wr && (wr_md != `DASMC_MD_PWRDN) && (wr_md != `DASMC_MD_IDLE);
    wire       wr_cal    = mode_wr && wr_md[2];

    wire       primary_converter_enable = converter_mode_control[`DASMC_BIT_PRI_EN];
    wire       aux_converter_enable     = converter_mode_control[`DASMC_BIT_AUX_EN];
    wire       mode_select_bit2         = converter_mode_control[2];
    wire       mode_select_bit1         = converter_mode_control[1];
    wire       mode_select_bit0         = converter_mode_control[0];
    wire       primary_ready_flag       = converter_status_flags[`DASMC_BIT_PRI_RDY];
    wire       aux_ready_flag           = converter_status_flags[`DASMC_BIT_AUX_RDY];
    wire       missing_reference_flag   = converter_status_flags[`DASMC_BIT_NOREF];

    wire       cur_cal    = mode_select_bit2;
    wire       cur_single = (mode_select == `DASMC_MD_SINGLE);
    wire       pri_active = primary_converter_enable && (mode_select != `DASMC_MD_PWRDN);
    wire       aux_active = aux_converter_enable && (mode_select != `DASMC_MD_PWRDN);
    // Done events only count while the converter is running and not held by ready.
    wire       pri_ev     = pri_done && pri_active && !primary_ready_flag;
    wire       aux_ev     = aux_done && aux_active && !aux_ready_flag;
    wire       aux_tcal   = cur_cal && aux_temp_selected;

    assign mode_select = {mode_select_bit2, mode_select_bit1, mode_select_bit0};
    assign pri_run = pri_active;
    assign aux_run = aux_active;
    // Every mode write pulses converter_restart, whether or not the mode bits change; aux_restart only when aux enable rises.
    // A rising primary enable only happens through a mode write, so it is covered too.
    assign converter_restart = mode_wr;
    assign aux_restart   = mode_wr && wr_aux_en && !aux_converter_enable;
    assign pri_result_we = pri_ev && !cur_cal;
    assign aux_result_we = aux_ev && !cur_cal;
    assign pri_coef_we   = pri_ev && cur_cal && !pri_cal_fault;
    assign aux_coef_we   = aux_ev && cur_cal && !aux_cal_fault && !aux_tcal;
    assign pri_clamp_ones = missing_reference_flag && pri_ext_ref;
    assign aux_clamp_ones = missing_reference_flag && aux_ext_ref;

    always @*
    begin
        next_mode   = converter_mode_control;
        next_status = converter_status_flags;
        if (mode_wr)
        begin
            next_mode = sfr_wdata & `DASMC_MODE_WMASK;
        end
        if (status_wr)
        begin
            // Software may only clear ready bits 7 and 6; zero writes clear them, ones leave them, bits 5 to 2 ignore writes.
            next_status = converter_status_flags & (sfr_wdata | 8'h3c) & `DASMC_STATUS_WMASK;
        end
        if (wr_start)
        begin
            if (wr_pri_en)
            begin
                next_status[`DASMC_BIT_PRI_RDY] = 1'b0;
            end
            if (wr_aux_en)
            begin
                next_status[`DASMC_BIT_AUX_RDY] = 1'b0;
            end
            next_status[`DASMC_BIT_CAL]     = 1'b0;
            next_status[`DASMC_BIT_PRI_ERR] = 1'b0;
            next_status[`DASMC_BIT_AUX_ERR] = 1'b0;
        end
        if (wr_cal)
        begin
            next_status[`DASMC_BIT_PRI_RDY] = 1'b0;
            next_status[`DASMC_BIT_AUX_RDY] = 1'b0;
        end
        // Hardware events win over any clear in the same cycle.
        if (pri_ev)
        begin
            next_status[`DASMC_BIT_PRI_RDY] = 1'b1;
            if (cur_cal)
            begin
                next_status[`DASMC_BIT_CAL] = 1'b1;
                if (pri_cal_fault)
                begin
                    next_status[`DASMC_BIT_PRI_ERR] = 1'b1;
                end
            end
            else if (pri_saturated)
            begin
                next_status[`DASMC_BIT_PRI_ERR] = 1'b1;
            end
        end
        if (aux_ev)
        begin
            next_status[`DASMC_BIT_AUX_RDY] = 1'b1;
            if (cur_cal)
            begin
                next_status[`DASMC_BIT_CAL] = 1'b1;
                if (aux_cal_fault || aux_tcal)
                begin
                    next_status[`DASMC_BIT_AUX_ERR] = 1'b1;
                end
            end
            else if (aux_saturated)
            begin
                next_status[`DASMC_BIT_AUX_ERR] = 1'b1;
            end
        end
        if (pri_active || aux_active)
        begin
            next_status[`DASMC_BIT_NOREF] = reference_missing;
        end
        else
        begin
            next_status[`DASMC_BIT_NOREF] = 1'b0;
        end
        // Single conversion or calibration falls back to power-down when done.
        if (!mode_wr && (cur_single || cur_cal) && (pri_ev || aux_ev))
        begin
            next_mode[2:0] = `DASMC_MD_PWRDN;
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            converter_mode_control <= `DASMC_MODE_RESET;
            converter_status_flags <= `DASMC_STATUS_RESET;
            sfr_rdata              <= 8'h00;
        end
        else
        begin
            converter_mode_control <= next_mode;
            converter_status_flags <= next_status;
            if (sfr_rd && sfr_addr == `DASMC_ADDR_MODE)
            begin
                sfr_rdata <= converter_mode_control;
            end
            else if (sfr_rd && sfr_addr == `DASMC_ADDR_STATUS)
            begin
                sfr_rdata <= converter_status_flags;
            end
            else if (sfr_rd)
            begin
                sfr_rdata <= 8'h00;
            end
        end
    end

endmodule

// ### verilog/dasmc_defines.vh
// Constants for the dual converter status and mode control block.
`ifndef DASMC_DEFINES_VH
`define DASMC_DEFINES_VH
`define DASMC_ADDR_MODE      8'hd1
`define DASMC_ADDR_STATUS    8'hd8
`define DASMC_MODE_RESET     8'h00
`define DASMC_STATUS_RESET   8'h00
`define DASMC_MODE_WMASK     8'h37
`define DASMC_STATUS_WMASK   8'hfc
`define DASMC_BIT_PRI_EN     5
`define DASMC_BIT_AUX_EN     4
`define DASMC_BIT_PRI_RDY    7
`define DASMC_BIT_AUX_RDY    6
`define DASMC_BIT_CAL        5
`define DASMC_BIT_NOREF      4
`define DASMC_BIT_PRI_ERR    3
`define DASMC_BIT_AUX_ERR    2
`define DASMC_MD_PWRDN       3'h0
`define DASMC_MD_IDLE        3'h1
`define DASMC_MD_SINGLE      3'h2
`define DASMC_MD_CONT        3'h3
`endif
